// ===== psc_ctrl.v
// apb-programmed host controller for a 4m x 16 pseudo-static ram
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "psc_regs.vh"
// Contract
// - after power-up hold standby low for settle time, chip select high, then raise standby
// - after standby rises keep chip select and standby high for release interval
// - standby pin is low from reset onward, before supply ramps
// - zero density needs full initialization again after partial standby
// - page read uses three lowest address bits, others held stable; the controller issues single-word reads only, with no page read
// - programming is two reads then two writes of the top address
// - first write data zero, second write selects density codes four to seven
// - chip select pulses between all four cycles, output enable toggles on reads
// - standby pin is high outside initialization and partial refresh standby
module psc_ctrl #(
    parameter SETTLE_CYC  = (`PSC_T_SETTLE_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS,
    parameter RELEASE_CYC = (`PSC_T_RELEASE_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS
) (
    input  wire                core_clk,
    input  wire                resetn,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output wire                pready,
    output wire                pslverr,
    output wire                chip_select_n,
    output wire                out_enable_n,
    output wire                write_enable_n,
    output wire                low_byte_select_n,
    output wire                high_byte_select_n,
    output reg                 standby_n,
    output wire [`PSC_AW-1:0]  mem_addr,
    input  wire [`PSC_DW-1:0]  dq_in,
    output wire [`PSC_DW-1:0]  dq_out,
    output wire                dq_oe
);
    localparam ACC_CYC  = (`PSC_T_ACCESS_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS;
    localparam HIGH_CYC = (`PSC_T_HIGH_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS;
    localparam S_IDLE    = 3'd0;
    localparam S_SETTLE  = 3'd1;
    localparam S_RELEASE = 3'd2;
    localparam S_RDY     = 3'd3;
    localparam S_CYCLE   = 3'd4;
    localparam S_SLEEP   = 3'd5;

    // ************************************************************
    // registers
    // ************************************************************
    reg [2:0]          state_q;
    reg [`PSC_CNT_W-1:0] cnt_q;
    reg [2:0]          cmd_q;
    reg [1:0]          be_n_q;
    reg [1:0]          dens_q;
    reg [`PSC_AW-1:0]  addr_q;
    reg [`PSC_DW-1:0]  wdata_q;
    reg                ready_q;
    reg                dens_ok_q;
    reg [1:0]          step_q;
    reg                cyc_start;
    reg                cyc_write;
    reg [`PSC_AW-1:0]  cyc_addr;
    reg [`PSC_DW-1:0]  cyc_data;
    wire               cyc_done;
    wire [`PSC_DW-1:0] cyc_rdata;

    function [`PSC_CNT_W-1:0] cyc_count;
        input integer n;
        begin
            cyc_count = (n < 1) ? 16'h0001 : n[`PSC_CNT_W-1:0];
        end
    endfunction

    // ************************************************************
    // apb slave
    // ************************************************************
    wire wr_en = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    wire busy = (state_q != S_RDY) && (state_q != S_SLEEP) && (state_q != S_IDLE);
    wire cmd_wr = wr_en && (paddr == `PSC_OFF_CTRL);

    always @* begin
        case (paddr)
            `PSC_OFF_CTRL:   prdata = {22'h000000, dens_q, 2'h0, be_n_q, 1'b0, cmd_q};
            `PSC_OFF_ADDR:   prdata = {10'h000, addr_q};
            `PSC_OFF_WDATA:  prdata = {16'h0000, wdata_q};
            `PSC_OFF_RDATA:  prdata = {16'h0000, cyc_rdata};
            `PSC_OFF_STATUS: prdata = {28'h0000000, dens_ok_q, state_q == S_SLEEP, ready_q, busy};
            default:         prdata = 32'h00000000;
        endcase
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            addr_q  <= 22'h000000;
            wdata_q <= 16'h0000;
            be_n_q  <= 2'h0;
            dens_q  <= 2'h0;
        end else if (wr_en) begin
            if (paddr == `PSC_OFF_ADDR)
                addr_q <= pwdata[`PSC_AW-1:0];
            if (paddr == `PSC_OFF_WDATA)
                wdata_q <= pwdata[`PSC_DW-1:0];
            if (cmd_wr && !busy) begin
                be_n_q <= {pwdata[`PSC_CTRL_BE_HI], pwdata[`PSC_CTRL_BE_LO]};
                dens_q <= pwdata[`PSC_CTRL_DENS_MSB:`PSC_CTRL_DENS_LSB];
            end
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    wire [2:0] new_cmd = pwdata[`PSC_CMD_MSB:`PSC_CMD_LSB];

    always @* begin
        cyc_write = (cmd_q == `PSC_CMD_WRITE) || (cmd_q == `PSC_CMD_PROG && step_q[1]);
        cyc_addr  = (cmd_q == `PSC_CMD_PROG) ? `PSC_TOP_ADDR : addr_q;
        if (cmd_q == `PSC_CMD_PROG)
            cyc_data = (step_q == 2'd2) ? `PSC_PROG_FIRST : (`PSC_PROG_BASE | {14'h0000, dens_q});
        else
            cyc_data = wdata_q;
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= S_IDLE;
            standby_n <= 1'b0;
            cnt_q     <= 16'h0000;
            cmd_q     <= `PSC_CMD_NONE;
            ready_q   <= 1'b0;
            dens_ok_q <= 1'b0;
            step_q    <= 2'd0;
            cyc_start <= 1'b0;
        end else begin
            cyc_start <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (cmd_wr && new_cmd == `PSC_CMD_INIT) begin
                        standby_n <= 1'b0;
                        ready_q   <= 1'b0;
                        cnt_q     <= cyc_count(SETTLE_CYC);
                        state_q   <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    if (cnt_q == 16'h0001) begin
                        standby_n <= 1'b1;
                        cnt_q     <= cyc_count(RELEASE_CYC);
                        state_q   <= S_RELEASE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                S_RELEASE: begin
                    if (cnt_q == 16'h0001) begin
                        ready_q <= 1'b1;
                        state_q <= S_RDY;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                S_RDY: begin
                    if (cmd_wr) begin
                        cmd_q  <= new_cmd;
                        step_q <= 2'd0;
                        case (new_cmd)
                            `PSC_CMD_READ, `PSC_CMD_WRITE, `PSC_CMD_PROG: begin
                                cyc_start <= 1'b1;
                                state_q   <= S_CYCLE;
                            end
                            `PSC_CMD_SLEEP: begin
                                standby_n <= 1'b0;
                                state_q   <= S_SLEEP;
                            end
                            `PSC_CMD_INIT: begin
                                standby_n <= 1'b0;
                                ready_q   <= 1'b0;
                                cnt_q     <= cyc_count(SETTLE_CYC);
                                state_q   <= S_SETTLE;
                            end
                            default: state_q <= S_RDY;
                        endcase
                    end
                end
                S_CYCLE: begin
                    if (cyc_done) begin
                        if (cmd_q == `PSC_CMD_PROG && step_q != 2'd3) begin
                            step_q    <= step_q + 2'd1;
                            cyc_start <= 1'b1;
                        end else begin
                            if (cmd_q == `PSC_CMD_PROG)
                                dens_ok_q <= 1'b1;
                            state_q <= S_RDY;
                        end
                    end
                end
                S_SLEEP: begin
                    if (cmd_wr && new_cmd == `PSC_CMD_WAKE) begin
                        if (dens_q == `PSC_DENS_ZERO) begin
                            ready_q <= 1'b0;
                            cnt_q   <= cyc_count(SETTLE_CYC);
                            state_q <= S_SETTLE;
                        end else begin
                            standby_n <= 1'b1;
                            state_q   <= S_RDY;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    psc_cycle #(
        .ACC_CYC  (ACC_CYC),
        .HIGH_CYC (HIGH_CYC)
    ) u_cycle (
        .core_clk           (core_clk),
        .resetn             (resetn),
        .start              (cyc_start),
        .is_write           (cyc_write),
        .addr               (cyc_addr),
        .wdata              (cyc_data),
        .be_n               ((cmd_q == `PSC_CMD_PROG) ? 2'h0 : be_n_q),
        .dq_in              (dq_in),
        .done               (cyc_done),
        .rdata_q            (cyc_rdata),
        .chip_select_n      (chip_select_n),
        .out_enable_n       (out_enable_n),
        .write_enable_n     (write_enable_n),
        .low_byte_select_n  (low_byte_select_n),
        .high_byte_select_n (high_byte_select_n),
        .mem_addr           (mem_addr),
        .dq_out             (dq_out),
        .dq_oe              (dq_oe)
    );
endmodule // psc_ctrl

// ===== psc_regs.vh
// register map, ctrl command codes and timing constants of the pseudo-static ram controller
`ifndef PSC_REGS_VH
`define PSC_REGS_VH
// apb register offsets
`define PSC_OFF_CTRL      12'h000
`define PSC_OFF_ADDR      12'h004
`define PSC_OFF_WDATA     12'h008
`define PSC_OFF_RDATA     12'h00C
`define PSC_OFF_STATUS    12'h010
// ctrl fields
`define PSC_CMD_LSB       0
`define PSC_CMD_MSB       2
`define PSC_CTRL_BE_LO    4
`define PSC_CTRL_BE_HI    5
`define PSC_CTRL_DENS_LSB 8
`define PSC_CTRL_DENS_MSB 9
// commands
`define PSC_CMD_NONE      3'h0
`define PSC_CMD_READ      3'h1
`define PSC_CMD_WRITE     3'h2
`define PSC_CMD_INIT      3'h3
`define PSC_CMD_PROG      3'h4
`define PSC_CMD_SLEEP     3'h5
`define PSC_CMD_WAKE      3'h6
// status bits
`define PSC_ST_BUSY       0
`define PSC_ST_READY      1
`define PSC_ST_SLEEP      2
`define PSC_ST_DENS_OK    3
// mode register sequence
`define PSC_TOP_ADDR      22'h3FFFFF
`define PSC_PROG_FIRST    16'h0000
`define PSC_PROG_BASE     16'h0004
`define PSC_DENS_ZERO     2'h3
// widths
`define PSC_AW            22
`define PSC_DW            16
// timings in ns at a 10 ns clock
`define PSC_CLK_NS        10
`define PSC_T_SETTLE_NS   200000
`define PSC_T_RELEASE_NS  300000
`define PSC_T_ACCESS_NS   70
`define PSC_T_HIGH_NS     20
`define PSC_CNT_W         16
`endif

// ===== psc_cycle.v
// one asynchronous sram-style bus cycle on the pins
`timescale 1ns/1ps
`include "psc_regs.vh"
module psc_cycle #(
    parameter ACC_CYC  = 7,
    parameter HIGH_CYC = 2
) (
    input  wire                core_clk,
    input  wire                resetn,
    input  wire                start,
    input  wire                is_write,
    input  wire [`PSC_AW-1:0]  addr,
    input  wire [`PSC_DW-1:0]  wdata,
    input  wire [1:0]          be_n,
    input  wire [`PSC_DW-1:0]  dq_in,
    output reg                 done,
    output reg  [`PSC_DW-1:0]  rdata_q,
    output reg                 chip_select_n,
    output reg                 out_enable_n,
    output reg                 write_enable_n,
    output reg                 low_byte_select_n,
    output reg                 high_byte_select_n,
    output reg  [`PSC_AW-1:0]  mem_addr,
    output reg  [`PSC_DW-1:0]  dq_out,
    output reg                 dq_oe
);
    localparam S_IDLE = 2'd0;
    localparam S_ACC  = 2'd1;
    localparam S_HIGH = 2'd2;
    reg [1:0] state_q;
    reg [3:0] cnt_q;
    reg [`PSC_DW-1:0] dq_s1_q;
    reg [`PSC_DW-1:0] dq_s2_q;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    // chip select pulses high after each cycle so cycles are always separated
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q            <= S_IDLE;
            cnt_q              <= 4'h0;
            done               <= 1'b0;
            rdata_q            <= 16'h0000;
            chip_select_n      <= 1'b1;
            out_enable_n       <= 1'b1;
            write_enable_n     <= 1'b1;
            low_byte_select_n  <= 1'b1;
            high_byte_select_n <= 1'b1;
            mem_addr           <= 22'h000000;
            dq_out             <= 16'h0000;
            dq_oe              <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        state_q            <= S_ACC;
                        cnt_q              <= ACC_CYC[3:0];
                        mem_addr           <= addr;
                        dq_out             <= wdata;
                        dq_oe              <= is_write;
                        chip_select_n      <= 1'b0;
                        out_enable_n       <= is_write;
                        write_enable_n     <= ~is_write;
                        low_byte_select_n  <= be_n[0];
                        high_byte_select_n <= be_n[1];
                    end
                end
                S_ACC: begin
                    if (cnt_q == 4'h0) begin
                        rdata_q        <= dq_s2_q;
                        chip_select_n  <= 1'b1;
                        out_enable_n   <= 1'b1;
                        write_enable_n <= 1'b1;
                        dq_oe          <= 1'b0;
                        cnt_q          <= HIGH_CYC[3:0];
                        state_q        <= S_HIGH;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                S_HIGH: begin
                    if (cnt_q == 4'h0) begin
                        done    <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule // psc_cycle

// ===== psc_ctrl_monitor.sv
// pin-level assertion checker for the psram host controller
`timescale 1ns/1ps
`include "psc_regs.vh"
module psc_ctrl_monitor #(
    parameter SETTLE_CYC  = 4,
    parameter RELEASE_CYC = 4
) (
    input wire               core_clk,
    input wire               resetn,
    input wire               chip_select_n,
    input wire               out_enable_n,
    input wire               write_enable_n,
    input wire               standby_n,
    input wire [`PSC_AW-1:0] mem_addr,
    input wire [`PSC_DW-1:0] dq_out,
    input wire               dq_oe
);
    // ****************************************
    // standby run lengths
    // ****************************************
    int   lo_cnt_q;
    int   hi_cnt_q;
    logic up_q;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lo_cnt_q <= 0;
            hi_cnt_q <= 0;
            up_q     <= 1'b0;
        end else begin
            lo_cnt_q <= standby_n ? 0 : lo_cnt_q + 1;
            up_q     <= up_q | standby_n;
            // a long low phase restarts the release window
            if (!standby_n)
                hi_cnt_q <= (lo_cnt_q + 1 >= SETTLE_CYC) ? 0 : RELEASE_CYC;
            else if (hi_cnt_q < RELEASE_CYC)
                hi_cnt_q <= hi_cnt_q + 1;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence acc_s; !chip_select_n [*8]; endsequence
    sequence gap_s; chip_select_n [*3]; endsequence
    settle_time_a: assert property ($rose(standby_n) && !up_q |-> lo_cnt_q >= SETTLE_CYC)
        else $error("standby raised early");
    select_first_a: assert property ($rose(standby_n) |-> chip_select_n)
        else $error("select low at standby rise");
    release_hold_a: assert property (hi_cnt_q < RELEASE_CYC && standby_n |-> chip_select_n)
        else $error("access inside release interval");
    reset_low_a: assert property ($rose(resetn) |-> !standby_n)
        else $error("standby high after reset");
    sleep_idle_a: assert property (!standby_n |-> chip_select_n)
        else $error("access during partial standby");
    cycle_shape_a: assert property ($fell(chip_select_n) |-> acc_s ##1 gap_s)
        else $error("select pulse shape wrong");
    read_strobe_a: assert property (!out_enable_n |-> !chip_select_n && write_enable_n && !dq_oe)
        else $error("output enable outside read");
    addr_hold_a: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(mem_addr))
        else $error("address moved in cycle");
    write_drive_a: assert property (!write_enable_n |-> dq_oe && !chip_select_n && out_enable_n)
        else $error("write strobe without data drive");
endmodule // psc_ctrl_monitor

bind psc_ctrl psc_ctrl_monitor #(.SETTLE_CYC(SETTLE_CYC), .RELEASE_CYC(RELEASE_CYC)) mon_u (
    .core_clk(core_clk), .resetn(resetn), .chip_select_n(chip_select_n),
    .out_enable_n(out_enable_n), .write_enable_n(write_enable_n), .standby_n(standby_n),
    .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe));

// ===== psc_dev_model.sv
// behavioural model of the pseudo-static ram device
`timescale 1ns/1ps
`include "psc_regs.vh"
module psc_dev_model (
    input  wire                core_clk,
    input  wire                chip_select_n,
    input  wire                out_enable_n,
    input  wire                write_enable_n,
    input  wire                low_byte_select_n,
    input  wire                high_byte_select_n,
    input  wire                standby_n,
    input  wire  [`PSC_AW-1:0] mem_addr,
    input  wire  [`PSC_DW-1:0] dq_out,
    output logic [`PSC_DW-1:0] dq_in,
    output logic [1:0]         dens_q,
    output int                 prog_cnt
);
    logic [15:0] mem [int];
    logic [21:0] a_q;
    logic [15:0] d_q;
    logic [1:0]  be_q;
    logic [1:0]  st_q = 2'h0;
    logic        wr_q = 1'b0;
    logic        cs_q = 1'b1;
    logic        sb_q = 1'b0;
    int          ks[$];
    initial begin
        dq_in    = 16'h5A5A;
        dens_q   = 2'hX;
        prog_cnt = 0;
    end
    function automatic logic [15:0] lane(input logic [15:0] w, input logic [15:0] old, input logic [1:0] bn);
        return {bn[1] ? old[15:8] : w[15:8], bn[0] ? old[7:0] : w[7:0]};
    endfunction
    always @(posedge core_clk) begin
        cs_q <= chip_select_n;
        sb_q <= standby_n;
        if (!chip_select_n) begin
            a_q  <= mem_addr;
            d_q  <= dq_out;
            wr_q <= !write_enable_n;
            be_q <= {high_byte_select_n, low_byte_select_n};
        end
        // released lanes toggle, never hold the last value
        if (!chip_select_n && !out_enable_n && standby_n)
            dq_in <= lane(mem.exists(mem_addr) ? mem[mem_addr] : ~dq_in, ~dq_in,
                          {high_byte_select_n, low_byte_select_n});
        else
            dq_in <= ~dq_in;
        if (chip_select_n && !cs_q) begin
            if (!wr_q)
                st_q <= (a_q == `PSC_TOP_ADDR && st_q < 2'h2) ? st_q + 2'h1 : 2'h0;
            else if (a_q == `PSC_TOP_ADDR && st_q == 2'h2 && d_q == `PSC_PROG_FIRST)
                st_q <= 2'h3;
            else if (a_q == `PSC_TOP_ADDR && st_q == 2'h3 && d_q[15:2] == 14'h1) begin
                dens_q   <= d_q[1:0];
                prog_cnt <= prog_cnt + 1;
                mem.delete();
                st_q     <= 2'h0;
            end else begin
                mem[a_q] = lane(d_q, mem.exists(a_q) ? mem[a_q] : 16'h0000, be_q);
                st_q     <= 2'h0;
            end
        end
        // partial standby drops what lies beyond the retained region
        if (!standby_n && sb_q) begin
            ks.delete();
            foreach (mem[k])
                if ((dens_q !== 2'h0 && dens_q !== 2'h1 && dens_q !== 2'h2) || k > (22'h0FFFFF >> dens_q))
                    ks.push_back(k);
            foreach (ks[j])
                mem.delete(ks[j]);
        end
    end
endmodule // psc_dev_model

// ===== psc_ctrl_tb_top.sv
// self-checking bench for the psram host controller
`timescale 1ns/1ps
`include "psc_regs.vh"
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module psc_ctrl_tb_top;
    typedef struct {logic [31:0] e; logic [31:0] m; string nm;} psc_note_t;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire  [21:0] mem_addr;
    wire  [15:0] dq_in, dq_out;
    wire  [1:0]  dens_q;
    wire         pready, pslverr, chip_select_n, out_enable_n, write_enable_n;
    wire         low_byte_select_n, high_byte_select_n, standby_n, dq_oe;
    int          prog_cnt, i;
    int          error_cnt = 0;
    int          samples_checked = 0;
    psc_note_t   nq[$];
    psc_note_t   nt;
    logic [21:0] ma[4];
    logic [15:0] md[4];
    always #5 core_clk = ~core_clk;
    psc_ctrl #(.SETTLE_CYC(4), .RELEASE_CYC(4)) dut_u (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chip_select_n(chip_select_n), .out_enable_n(out_enable_n), .write_enable_n(write_enable_n),
        .low_byte_select_n(low_byte_select_n), .high_byte_select_n(high_byte_select_n),
        .standby_n(standby_n), .mem_addr(mem_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    psc_dev_model dev_u (
        .core_clk(core_clk), .chip_select_n(chip_select_n), .out_enable_n(out_enable_n),
        .write_enable_n(write_enable_n), .low_byte_select_n(low_byte_select_n),
        .high_byte_select_n(high_byte_select_n), .standby_n(standby_n), .mem_addr(mem_addr),
        .dq_out(dq_out), .dq_in(dq_in), .dens_q(dens_q), .prog_cnt(prog_cnt));
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 50) begin n++; @(posedge core_clk); end
        if (n >= 50) begin error_cnt++; print_verdict(); end
        r = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
        logic [31:0] r;
        nq.push_back('{e & m, m, nm});
        apb(1'b0, a, 32'h0, r);
    endtask
    task automatic cmd(input logic [31:0] c);
        logic [31:0] r;
        int n;
        apb(1'b1, `PSC_OFF_CTRL, c, r);
        r = 32'h1;
        for (n = 0; n < 200 && r[0] !== 1'b0; n++) begin
            nq.push_back('{32'h0, 32'h0, "poll"});
            apb(1'b0, `PSC_OFF_STATUS, 32'h0, r);
        end
        if (n >= 200) begin error_cnt++; print_verdict(); end
    endtask
    task automatic mwr(input logic [21:0] a, input logic [15:0] d, input logic [31:0] c);
        logic [31:0] r;
        apb(1'b1, `PSC_OFF_ADDR, {10'h0, a}, r);
        apb(1'b1, `PSC_OFF_WDATA, {16'h0, d}, r);
        cmd(c);
    endtask
    task automatic mrd(input logic [21:0] a, input logic [15:0] e, input string nm);
        logic [31:0] r;
        apb(1'b1, `PSC_OFF_ADDR, {10'h0, a}, r);
        cmd(`PSC_CMD_READ);
        rd(`PSC_OFF_RDATA, {16'h0, e}, 32'hFFFF, nm);
    endtask
    // ****************************************
    // result watcher
    // ****************************************
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = nq.pop_front();
            if (nt.m != 32'h0)
                `CHK(nt.nm, nt.e, prdata & nt.m)
        end
        if (psel && penable && pready === 1'b1)
            `CHK("slave error", 1'b0, pslverr)
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(74528));
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        mwr(22'h10, 16'h1234, `PSC_CMD_WRITE);
        rd(`PSC_OFF_STATUS, 32'h0, 32'h3, "status pre init");
        cmd(`PSC_CMD_INIT);
        rd(`PSC_OFF_STATUS, 32'h2, 32'h3, "status post init");
        rd(12'h0FC, 32'h0, 32'hFFFFFFFF, "unmapped");
        for (i = 0; i < 4; i++) begin
            ma[i] = 22'($urandom % 32'h3FFFFF);
            md[i] = 16'($urandom);
            mwr(ma[i], md[i], `PSC_CMD_WRITE);
        end
        for (i = 3; i >= 0; i--)
            mrd(ma[i], md[i], "random word");
        mwr(ma[0], 16'hFFFF, `PSC_CMD_WRITE | 32'h20);
        mrd(ma[0], {md[0][15:8], 8'hFF}, "byte write");
        rd(`PSC_OFF_ADDR, {10'h0, ma[0]}, 32'hFFFFFFFF, "address reg");
        rd(`PSC_OFF_WDATA, 32'h0000FFFF, 32'hFFFFFFFF, "write data reg");
        rd(`PSC_OFF_CTRL, 32'h00000001, 32'hFFFFFFFF, "control reg");
        for (i = 0; i < 4; i++) begin
            cmd(`PSC_CMD_PROG | (i << 8));
            `CHK("density", 2'(i), dens_q)
            `CHK("program count", i + 1, prog_cnt)
        end
        rd(`PSC_OFF_STATUS, 32'h8, 32'h8, "programmed");
        cmd(`PSC_CMD_SLEEP | 32'h300);
        rd(`PSC_OFF_STATUS, 32'h4, 32'h4, "sleeping");
        cmd(`PSC_CMD_WAKE | 32'h300);
        rd(`PSC_OFF_STATUS, 32'h2, 32'h6, "reinit done");
        mwr(ma[1], md[1], `PSC_CMD_WRITE);
        mrd(ma[1], md[1], "after reinit");
        cmd(`PSC_CMD_PROG | 32'h100);
        mwr(22'h07FFFF, md[2], `PSC_CMD_WRITE);
        mwr(22'h000000, md[3], `PSC_CMD_WRITE);
        cmd(`PSC_CMD_SLEEP | 32'h100);
        cmd(`PSC_CMD_WAKE | 32'h100);
        mrd(22'h07FFFF, md[2], "retained top");
        mrd(22'h000000, md[3], "retained base");
        print_verdict();
    end
endmodule // psc_ctrl_tb_top
